/* rtl/adcsq_fifo.sv */
// Purpose: Sixteen-entry result memory with a registered head word.
// Assumes: Push and pop come from the core clock domain.
// Notes:   Head data trails a push or pop by one cycle; full drops pushes.
`timescale 1ns/1ns
module adcsq_fifo (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_push,
  input  wire logic [11:0] i_data,
  input  wire logic        i_pop,
  input  wire logic        i_clear,
  output logic      [11:0] o_head,
  output logic             o_empty
);
  logic [11:0] mem_q [adcsq_pkg::FIFO_DEPTH];
  logic [4:0]  wr_q;
  logic [4:0]  wr_d;
  logic [4:0]  rd_q;
  logic [4:0]  rd_d;
  logic        full;
  logic        empty;

  assign full  = (wr_q[3:0] == rd_q[3:0]) && (wr_q[4] != rd_q[4]);
  assign empty = (wr_q == rd_q);

  // Pointer update; clear wins over a same-cycle push
  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    if (i_clear) begin
      wr_d = 5'h00;
      rd_d = 5'h00;
    end else begin
      if (i_push && !full) wr_d = wr_q + 5'h01;
      if (i_pop && !empty) rd_d = rd_q + 5'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_q    <= 5'h00;
      rd_q    <= 5'h00;
      o_head  <= 12'h000;
      o_empty <= 1'b1;
    end else if (i_ce) begin
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      o_head  <= empty ? 12'h000 : mem_q[rd_q[3:0]];
      o_empty <= (wr_d == rd_d);
    end
  end

  // Storage has no reset so it maps onto plain memory
  always_ff @(posedge i_clk) begin
    if (i_ce && i_push && !full && !i_clear) mem_q[wr_q[3:0]] <= i_data;
  end
endmodule

/* rtl/adcsq_link.sv */
// Purpose: Serial port logic on the link clock.
// Assumes: Data in sampled on rising edges, data out changes on falling.
// Notes:   Chip select high holds the frame logic in reset.
`timescale 1ns/1ns
module adcsq_link (
  input  wire logic        i_sclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_cs_n,
  input  wire logic        i_din,
  input  wire logic [11:0] i_tx_word,
  input  wire logic        i_tx_valid,
  output logic             o_dout,
  output logic      [7:0]  o_rx_byte,
  output logic             o_rx_tgl,
  output logic             o_pop_tgl
);
  logic       frm_rst_n;
  logic [6:0] sh_q;
  logic [2:0] bit_q;
  logic [3:0] tx_cnt_q;
  logic [15:0] tx_q;
  logic       vs1_q;
  logic       vs2_q;

  // The link clock stops between frames, so the frame ends on select
  assign frm_rst_n = i_rst_n & ~i_cs_n;

  // Byte assembly; the finished byte holds for eight link clocks
  always_ff @(posedge i_sclk or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      sh_q  <= 7'h00;
      bit_q <= 3'h0;
    end else begin
      sh_q  <= {sh_q[5:0], i_din};
      bit_q <= bit_q + 3'h1;
    end
  end

  // Byte and its toggle survive the frame end for the core to read
  always_ff @(posedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rx_byte <= 8'h00;
      o_rx_tgl  <= 1'b0;
    end else if (!i_cs_n && bit_q == 3'h7) begin
      o_rx_byte <= {sh_q, i_din};
      o_rx_tgl  <= ~o_rx_tgl;
    end
  end

  // Valid level crosses by two flops inside each frame; the link clock
  // stops between frames, so a value kept from the last frame is stale
  always_ff @(negedge i_sclk or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      vs1_q <= 1'b0;
      vs2_q <= 1'b0;
    end else begin
      vs1_q <= i_tx_valid;
      vs2_q <= vs1_q;
    end
  end

  // Result words: four leading zeros, then twelve data bits, MSB first.
  // The head word loads on the fourth falling edge, once valid settled.
  always_ff @(negedge i_sclk or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      tx_cnt_q  <= 4'h0;
      tx_q      <= 16'h0000;
      o_dout    <= 1'b0;
    end else begin
      tx_cnt_q <= tx_cnt_q + 4'h1;
      if (tx_cnt_q < 4'h4) begin
        o_dout <= 1'b0;
        if (tx_cnt_q == 4'h3) begin
          tx_q <= {(vs2_q ? i_tx_word : 12'h000), 4'h0};
        end
      end else begin
        tx_q   <= {tx_q[14:0], 1'b0};
        o_dout <= tx_q[15];
      end
    end
  end

  // A word counts as read once loaded; the core then advances the head
  always_ff @(negedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pop_tgl <= 1'b0;
    end else if (!i_cs_n && tx_cnt_q == 4'h3 && vs2_q) begin
      o_pop_tgl <= ~o_pop_tgl;
    end
  end
endmodule

/* rtl/adcsq_pkg.sv */
// Purpose: Shared constants for the ADC conversion sequencer.
// Assumes: Core clock at 250 MHz, serial link on its own clock.
// Notes:   Control bytes are decoded by their leading header bits.
package adcsq_pkg;
  localparam int CLK_MHZ = 250;
  // Control byte headers and their positions
  localparam int          CONV_BIT    = 7;
  localparam logic [1:0]  SETUP_HDR   = 2'h1;   // bits 7:6
  localparam logic [2:0]  AVG_HDR     = 3'h1;   // bits 7:5
  localparam logic [3:0]  RST_HDR     = 4'h1;   // bits 7:4
  // Field positions
  localparam int AVG_EN_BIT   = 4;
  localparam int NAVG_HI      = 3;
  localparam int NAVG_LO      = 2;
  localparam int NSCAN_HI     = 1;
  localparam int NSCAN_LO     = 0;
  localparam int RST_FIFO_BIT = 3;
  localparam int CKSEL_HI     = 5;
  localparam int CKSEL_LO     = 4;
  localparam int REFSEL_HI    = 3;
  localparam int REFSEL_LO    = 2;
  localparam int DIFF_HI      = 1;
  localparam int CHSEL_HI     = 6;
  localparam int CHSEL_LO     = 3;
  localparam int SCAN_HI      = 2;
  localparam int SCAN_LO      = 1;
  localparam int TEMP_BIT     = 0;
  // Reset values
  localparam logic [7:0] SETUP_RST = 8'h20;     // clock mode 10
  localparam logic [7:0] AVG_RST   = 8'h00;
  localparam logic [7:0] CONV_RST  = 8'h00;
  // Clock modes, scan modes, reference modes
  localparam logic [1:0] CKM_CNV_SCAN = 2'h0;
  localparam logic [1:0] CKM_CNV_EACH = 2'h1;
  localparam logic [1:0] CKM_SER_SCAN = 2'h2;
  localparam logic [1:0] SCAN_UP     = 2'h0;
  localparam logic [1:0] SCAN_TOP    = 2'h1;
  localparam logic [1:0] SCAN_REP    = 2'h2;
  localparam logic [1:0] REF_INT_SLP = 2'h0;
  localparam logic [3:0] TOP_CHAN    = 4'hf;
  // Sizes
  localparam int DATA_W     = 12;
  localparam int FIFO_DEPTH = 16;
  // Timing: internal wake and acquisition times (plain defaults)
  localparam int WAKE_NS     = 1000;
  localparam int ACQ_NS      = 600;
  localparam int REF_WAKE_US = 65;
  localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int ACQ_CYC  = (ACQ_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [2:0] {
    ST_IDLE, ST_TRACK, ST_WAKE, ST_ACQ, ST_CONV
  } adcsq_state_e;
endpackage

/* rtl/adcsq_top.sv */
// Purpose: Conversion sequencer of a serial 12-bit converter.
// Assumes: Converter core answers a start pulse with a done pulse.
// Notes:   Link logic runs on the serial clock; bytes cross by toggle.
// Functional notes
// - Byte with top bits 001 writes the averaging register.
// - Averaging register bit 4 turns averaging on or off.
// - Average count field picks 4, 8, 16 or 32 conversions.
// - Averaging off means one conversion per result.
// - Repeat count returns 4, 8, 12 or 16 results; scan mode 10 only.
// - Byte with top bits 0001 is a reset write; bits 2:0 ignored.
// - Reset bit 3 low resets all registers; high clears only the FIFO.
// - Mode 00 start pulse runs wake, acquire, convert, shutdown.
// - After a mode 00 scan, results stored, then end flag low.
// - Modes 00/01 end flag stays low until select or start low.
// - Temperature result goes into the FIFO before channel results.
// - Mode 01 falling start wakes and tracks; host holds 1.4 us.
// - Mode 01 temperature is timed inside; host holds start 40 ns.
// - Mode 01 rising start ends acquisition and starts conversion.
// - Mode 01 averaging writes after enough pulses, then next channel.
// - Mode 01 temperature runs on first rising start after the byte.
// - Mode 10 is the reset default; conversion byte starts a scan.
// - Mode 10 end flag low after scan, released by select low.
// - Two setup bits give the clock mode and start source.
// - Registers reset to zero, setup register to clock mode 10.
`timescale 1ns/1ns
module adcsq_top #(
  parameter int REF_WAKE_CYC = adcsq_pkg::REF_WAKE_US * adcsq_pkg::CLK_MHZ
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic        i_din,
  input  wire logic        i_convert_start_n,
  input  wire logic        i_conv_done,
  input  wire logic [11:0] i_conv_data,
  output logic             o_dout,
  output logic             o_eoc_n,
  output logic             o_conv_start,
  output logic             o_conv_temp,
  output logic      [3:0]  o_conv_chan
);
  localparam logic [15:0] WAKE_LD = 16'(adcsq_pkg::WAKE_CYC - 1);
  localparam logic [15:0] ACQ_LD  = 16'(adcsq_pkg::ACQ_CYC - 1);
  localparam logic [15:0] REF_LD  = 16'(REF_WAKE_CYC - 1);

  // Number of conversions folded into one result
  function automatic logic [5:0] need_conv(input logic en,
                                           input logic [1:0] navg);
    need_conv = en ? (6'h04 << navg) : 6'h01;
  endfunction

  function automatic logic is_avg(input logic [7:0] b);
    is_avg = (b[7:5] == adcsq_pkg::AVG_HDR);
  endfunction

  function automatic logic is_rst(input logic [7:0] b);
    is_rst = (b[7:4] == adcsq_pkg::RST_HDR);
  endfunction

  // Synchronisers: first stage feeds only the second
  logic [2:0] cnv_s_q;
  logic [2:0] cs_s_q;
  logic [2:0] rx_s_q;
  logic [2:0] pop_s_q;
  logic       rx_tgl;
  logic       pop_tgl;
  logic [7:0] rx_byte;
  logic [11:0] fifo_head;
  logic        fifo_empty;
  logic        valid_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnv_s_q <= 3'h7;
      cs_s_q  <= 3'h7;
      rx_s_q  <= 3'h0;
      pop_s_q <= 3'h0;
      valid_q <= 1'b0;
    end else if (i_ce) begin
      cnv_s_q <= {cnv_s_q[1:0], i_convert_start_n};
      cs_s_q  <= {cs_s_q[1:0], i_cs_n};
      rx_s_q  <= {rx_s_q[1:0], rx_tgl};
      pop_s_q <= {pop_s_q[1:0], pop_tgl};
      valid_q <= ~fifo_empty;
    end
  end

  logic cnv_fall;
  logic cnv_rise;
  logic cnv_low;
  logic cs_low;
  logic byte_ev;
  logic pop_ev;
  assign cnv_fall = cnv_s_q[2] & ~cnv_s_q[1];
  assign cnv_rise = ~cnv_s_q[2] & cnv_s_q[1];
  assign cnv_low  = ~cnv_s_q[1];
  assign cs_low   = ~cs_s_q[1];
  assign byte_ev  = rx_s_q[2] ^ rx_s_q[1];
  assign pop_ev   = pop_s_q[2] ^ pop_s_q[1];

  adcsq_link u_link (
    .i_sclk     (i_sclk),
    .i_rst_n    (i_rst_n),
    .i_cs_n     (i_cs_n),
    .i_din      (i_din),
    .i_tx_word  (fifo_head),
    .i_tx_valid (valid_q),
    .o_dout     (o_dout),
    .o_rx_byte  (rx_byte),
    .o_rx_tgl   (rx_tgl),
    .o_pop_tgl  (pop_tgl)
  );

  // Control state
  adcsq_pkg::adcsq_state_e state_q, state_d;
  logic [7:0]  setup_q, setup_d;
  logic [7:0]  avg_q, avg_d;
  logic [7:0]  conv_q, conv_d;
  logic        skip_q, skip_d;
  logic        armed_q, armed_d;
  logic        s_en_q, s_en_d;
  logic [1:0]  s_navg_q, s_navg_d;
  logic [3:0]  start_q, start_d;
  logic [3:0]  last_q, last_d;
  logic [3:0]  chan_q, chan_d;
  logic [3:0]  rep_q, rep_d;
  logic [3:0]  rep_ld_q, rep_ld_d;
  logic        temp_q, temp_d;
  logic [5:0]  avg_cnt_q, avg_cnt_d;
  logic [16:0] acc_q, acc_d;
  logic [15:0] tmr_q, tmr_d;
  logic        eoc_n_d;
  logic        cst_d;
  logic        ctemp_d;
  logic [3:0]  cchan_d;
  logic        push;
  logic [11:0] push_data;
  logic        fifo_clr;
  logic [1:0]  ckm;
  logic        ref_slp;

  assign ckm     = setup_q[adcsq_pkg::CKSEL_HI:adcsq_pkg::CKSEL_LO];
  assign ref_slp = (setup_q[adcsq_pkg::REFSEL_HI:adcsq_pkg::REFSEL_LO]
                    == adcsq_pkg::REF_INT_SLP);

  // Next-state logic for sequencing and register writes
  always_comb begin
    logic [16:0] sum;
    logic [5:0]  cnt;
    logic        fin;
    logic        load;
    logic        go;
    logic [1:0]  scan;
    logic [3:0]  nch;
    sum = acc_q + {5'h00, i_conv_data};
    cnt = avg_cnt_q + 6'h01;
    fin = 1'b0;
    load = 1'b0;
    go = 1'b0;
    scan = conv_q[adcsq_pkg::SCAN_HI:adcsq_pkg::SCAN_LO];
    nch = 4'h0;
    state_d = state_q;   setup_d = setup_q;   avg_d = avg_q;
    conv_d = conv_q;     skip_d = skip_q;     armed_d = armed_q;
    s_en_d = s_en_q;     s_navg_d = s_navg_q; start_d = start_q;
    last_d = last_q;     chan_d = chan_q;     rep_d = rep_q;
    rep_ld_d = rep_ld_q; temp_d = temp_q;     avg_cnt_d = avg_cnt_q;
    acc_d = acc_q;       tmr_d = tmr_q;       eoc_n_d = o_eoc_n;
    cst_d = 1'b0;        ctemp_d = o_conv_temp;
    cchan_d = o_conv_chan;
    push = 1'b0;
    push_data = 12'h000;
    fifo_clr = 1'b0;
    scan = conv_q[adcsq_pkg::SCAN_HI:adcsq_pkg::SCAN_LO];
    // end flag released by select, or start in modes 00/01
    if (cs_low || (!ckm[1] && cnv_low)) eoc_n_d = 1'b1;
    unique case (state_q)
      adcsq_pkg::ST_IDLE: begin
        // mode 00 scan on the rising start edge
        if (ckm == adcsq_pkg::CKM_CNV_SCAN && cnv_rise) go = 1'b1;
        // mode 01 falling start wakes into track
        if (ckm == adcsq_pkg::CKM_CNV_EACH && cnv_fall && armed_q)
          state_d = adcsq_pkg::ST_TRACK;
      end
      adcsq_pkg::ST_TRACK: begin
        if (cnv_rise) begin
          if (temp_q) begin
            // temperature wake and measurement timed inside
            // temperature on first rising start after the byte
            state_d = adcsq_pkg::ST_WAKE;
            tmr_d = REF_LD;
          end else begin
            state_d = adcsq_pkg::ST_CONV;
            cst_d = 1'b1;
            ctemp_d = 1'b0;
            cchan_d = chan_q;
          end
        end
      end
      adcsq_pkg::ST_WAKE: begin
        if (tmr_q == 16'h0000) begin
          state_d = adcsq_pkg::ST_ACQ;
          tmr_d = ACQ_LD;
        end else begin
          tmr_d = tmr_q - 16'h0001;
        end
      end
      adcsq_pkg::ST_ACQ: begin
        if (tmr_q == 16'h0000) begin
          state_d = adcsq_pkg::ST_CONV;
          cst_d = 1'b1;
          ctemp_d = temp_q;
          cchan_d = chan_q;
        end else begin
          tmr_d = tmr_q - 16'h0001;
        end
      end
      adcsq_pkg::ST_CONV: begin
        if (i_conv_done) begin
          // accumulate until the averaging depth is reached
          // depth is one when averaging is off
          if (!temp_q && cnt < need_conv(s_en_q, s_navg_q)) begin
            acc_d = sum;
            avg_cnt_d = cnt;
            fin = (ckm == adcsq_pkg::CKM_CNV_EACH);
          end else begin
            push = 1'b1;
            push_data = temp_q ? i_conv_data :
                        12'(sum >> (s_en_q ? {1'b0, s_navg_q} + 3'h2
                                           : 3'h0));
            acc_d = 17'h00000;
            avg_cnt_d = 6'h00;
            // temperature result first, then channel list
            // after a full average, advance the multiplexer
            if (temp_q) begin
              temp_d = 1'b0;
            end else if (rep_q != 4'h0) begin
              rep_d = rep_q - 4'h1;
            end else if (chan_q != last_q) begin
              chan_d = chan_q + 4'h1;
            end
            fin = (ckm == adcsq_pkg::CKM_CNV_EACH) ||
                  (!temp_q && chan_q == last_q && rep_q == 4'h0);
            if (!temp_q && chan_q == last_q && rep_q == 4'h0) begin
              chan_d = start_q;
              rep_d = rep_ld_q;
              temp_d = conv_q[adcsq_pkg::TEMP_BIT];
            end
          end
          // shut down, then end flag low
          // mode 10 scan ends with end flag low
          if (fin) begin
            state_d = adcsq_pkg::ST_IDLE;
            eoc_n_d = 1'b0;
          end else begin
            state_d = adcsq_pkg::ST_ACQ;
            tmr_d = ACQ_LD;
          end
        end
      end
    endcase
    if (byte_ev) begin
      if (skip_q) begin
        skip_d = 1'b0;
      end else if (rx_byte[adcsq_pkg::CONV_BIT]) begin
        conv_d = rx_byte;
        scan = rx_byte[adcsq_pkg::SCAN_HI:adcsq_pkg::SCAN_LO];
        // mode 10 conversion byte starts a scan
        if (ckm == adcsq_pkg::CKM_SER_SCAN &&
            state_q == adcsq_pkg::ST_IDLE) go = 1'b1;
        if (ckm == adcsq_pkg::CKM_CNV_EACH) load = 1'b1;
      end else if (rx_byte[7:6] == adcsq_pkg::SETUP_HDR) begin
        setup_d = rx_byte;
        skip_d = rx_byte[adcsq_pkg::DIFF_HI];
      end else if (is_avg(rx_byte)) begin
        avg_d = rx_byte;
      end else if (is_rst(rx_byte)) begin
        fifo_clr = 1'b1;
      end
    end
    // settings snapshot when a scan starts or is armed
    if (go || load) begin
      nch = conv_d[adcsq_pkg::CHSEL_HI:adcsq_pkg::CHSEL_LO];
      s_en_d = avg_q[adcsq_pkg::AVG_EN_BIT];
      s_navg_d = avg_q[adcsq_pkg::NAVG_HI:adcsq_pkg::NAVG_LO];
      start_d = (scan == adcsq_pkg::SCAN_UP) ? 4'h0 : nch;
      last_d = (scan == adcsq_pkg::SCAN_TOP) ? adcsq_pkg::TOP_CHAN : nch;
      // repeat count only in scan mode 10
      rep_ld_d = (scan == adcsq_pkg::SCAN_REP) ?
                 {avg_q[adcsq_pkg::NSCAN_HI:adcsq_pkg::NSCAN_LO], 2'h3}
                 : 4'h0;
      chan_d = start_d;
      rep_d = rep_ld_d;
      temp_d = conv_d[adcsq_pkg::TEMP_BIT];
      acc_d = 17'h00000;
      avg_cnt_d = 6'h00;
      armed_d = load;
    end
    if (go) begin
      state_d = adcsq_pkg::ST_WAKE;
      eoc_n_d = 1'b1;
      tmr_d = (ref_slp || conv_d[adcsq_pkg::TEMP_BIT]) ? REF_LD : WAKE_LD;
    end
    // reset bit low restores every register
    if (byte_ev && !skip_q && !rx_byte[adcsq_pkg::CONV_BIT] &&
        is_rst(rx_byte) && !rx_byte[adcsq_pkg::RST_FIFO_BIT]) begin
      setup_d = adcsq_pkg::SETUP_RST;
      avg_d = adcsq_pkg::AVG_RST;
      conv_d = adcsq_pkg::CONV_RST;
      armed_d = 1'b0;
      state_d = adcsq_pkg::ST_IDLE;
      push = 1'b0;
    end
  end

  // power-up defaults, setup selects clock mode 10
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= adcsq_pkg::ST_IDLE;
      setup_q <= adcsq_pkg::SETUP_RST;
      avg_q <= adcsq_pkg::AVG_RST;
      conv_q <= adcsq_pkg::CONV_RST;
      skip_q <= 1'b0;      armed_q <= 1'b0;
      s_en_q <= 1'b0;      s_navg_q <= 2'h0;
      start_q <= 4'h0;     last_q <= 4'h0;
      chan_q <= 4'h0;      rep_q <= 4'h0;
      rep_ld_q <= 4'h0;    temp_q <= 1'b0;
      avg_cnt_q <= 6'h00;  acc_q <= 17'h00000;
      tmr_q <= 16'h0000;   o_eoc_n <= 1'b1;
      o_conv_start <= 1'b0;
      o_conv_temp <= 1'b0;
      o_conv_chan <= 4'h0;
    end else if (i_ce) begin
      state_q <= state_d;
      setup_q <= setup_d;
      avg_q <= avg_d;
      conv_q <= conv_d;
      skip_q <= skip_d;    armed_q <= armed_d;
      s_en_q <= s_en_d;    s_navg_q <= s_navg_d;
      start_q <= start_d;  last_q <= last_d;
      chan_q <= chan_d;    rep_q <= rep_d;
      rep_ld_q <= rep_ld_d; temp_q <= temp_d;
      avg_cnt_q <= avg_cnt_d; acc_q <= acc_d;
      tmr_q <= tmr_d;      o_eoc_n <= eoc_n_d;
      o_conv_start <= cst_d;
      o_conv_temp <= ctemp_d;
      o_conv_chan <= cchan_d;
    end
  end

  adcsq_fifo u_fifo (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_push  (push),
    .i_data  (push_data),
    .i_pop   (pop_ev),
    .i_clear (fifo_clr),
    .o_head  (fifo_head),
    .o_empty (fifo_empty)
  );
endmodule

/* verification/adcsq_assertions.sv */
// Purpose: Port checks of the conversion sequencer on the core clock.
// Assumes: Select and start pins pass a short synchroniser.
// Notes:   Release bounds allow a few cycles of synchroniser lag.
`timescale 1ns/1ns
module adcsq_checker #(
  parameter int REF_WAKE_CYC = 20
) (
  input logic       i_clk,
  input logic       i_rst_n,
  input logic       i_cs_n,
  input logic       i_convert_start_n,
  input logic       i_conv_done,
  input logic       o_eoc_n,
  input logic       o_conv_start,
  input logic       o_conv_temp,
  input logic [3:0] o_conv_chan
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Pins quiet long enough that no release can be in flight
  sequence s_pins_quiet;
    (i_cs_n && i_convert_start_n)[*4];
  endsequence
  sequence s_shut_down;
    s_pins_quiet ##0 !o_eoc_n;
  endsequence
  chk_start_single: assert property (o_conv_start |=> !o_conv_start)
    else $error("converter start longer than one cycle");
  chk_end_after_done: assert property
    ($fell(o_eoc_n) |-> $past(i_conv_done))
    else $error("end flag fell without a finished conversion");
  chk_end_holds: assert property (s_shut_down |=> !o_eoc_n)
    else $error("end flag released while pins were high");
  chk_sel_release: assert property
    (!o_eoc_n && !i_cs_n |-> ##[1:6] o_eoc_n)
    else $error("end flag not released by select");
  chk_start_release: assert property
    (!o_eoc_n && !i_convert_start_n |-> ##[1:6] o_eoc_n)
    else $error("end flag not released by start pin");
  chk_quiet_shutdown: assert property (s_shut_down |-> !o_conv_start)
    else $error("conversion started while shut down");
  chk_done_busy: assert property (i_conv_done |-> o_eoc_n)
    else $error("end flag low while a conversion was running");
  chk_chan_steady: assert property
    (o_conv_start |=> ($stable(o_conv_chan) && $stable(o_conv_temp))[*3])
    else $error("converter request changed mid conversion");
  chk_reset_idle: assert property
    (disable iff (1'b0) !i_rst_n |-> o_eoc_n && !o_conv_start)
    else $error("outputs not idle during reset");
endmodule

/* verification/adcsq_host.sv */
// Purpose: Host controller on the serial port and the start pin.
// Assumes: Link clock of 48 ns runs only inside frames.
// Notes:   Every frame is 16 clocks, so it also reads one word.
`timescale 1ns/1ns
module adcsq_host (
  input  logic i_clk,
  input  logic i_dout,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din,
  output logic o_convert_start_n
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din = 1'b1;
    o_convert_start_n = 1'b1;
  end
  // A byte then a zero byte; odd offsets keep the link out of phase
  task automatic frame(input logic [7:0] b, output logic [15:0] w);
    logic [15:0] sh;
    sh = {b, 8'h00};
    @(negedge i_clk);
    o_cs_n = 1'b0;
    for (int k = 0; k < 16; k++) begin
      o_din = sh[15 - k];
      #13 o_sclk = 1'b1;
      #24 o_sclk = 1'b0;
      #11 w = {w[14:0], i_dout};
    end
    o_cs_n = 1'b1;
    o_din = ~o_din; // Released line must not keep its last value
    // Select stays high a while so back-to-back frames really end
    repeat (2) @(negedge i_clk);
  endtask
  task automatic start_pulse(input int low_cyc);
    @(negedge i_clk);
    o_convert_start_n = 1'b0;
    repeat (low_cyc) @(negedge i_clk);
    o_convert_start_n = 1'b1;
  endtask
endmodule

/* verification/test_adc_conversion_sequencer.sv */
// Purpose: Self-checking bench of the ADC conversion sequencer.
// Assumes: Converter stub answers every start four cycles later.
// Notes:   Short reference wake keeps the averaging runs brief.
`timescale 1ns/1ns
`define CHECK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
  mismatches++; $display("wrong value at %0t: got %0h exp %0h", $time, \
  got, exp); end end
module test_adc_conversion_sequencer;
  localparam int REF_WAKE_CYC = 20;
  typedef struct {
    logic [7:0] avg;
    logic [7:0] conv;
    int         n;
    int         res;
  } adcsq_row_s;
  adcsq_row_s rows [7] = '{'{8'h2c, 8'h9e, 1, 1}, '{8'h30, 8'h9e, 4, 1},
    '{8'h34, 8'h9e, 8, 1}, '{8'h38, 8'h9e, 16, 1}, '{8'h3c, 8'h9e, 32, 1},
    '{8'h20, 8'h9c, 1, 4}, '{8'h23, 8'h9c, 1, 16}};
  logic        clk = 1'b0;
  logic        rst_n = 1'b1;
  logic        sclk, cs_n, din, convert_start_n_n, dout, eoc_n;
  logic        conv_start, conv_temp, first_temp;
  logic        conv_done = 1'b0;
  logic [11:0] conv_data = 12'h000;
  logic [3:0]  conv_chan, last_chan;
  logic [2:0]  dly = 3'h0;
  logic [15:0] word;
  int          n_conv, mismatches, n_tests;
  always #2 clk = ~clk;
  adcsq_top #(.REF_WAKE_CYC(REF_WAKE_CYC)) DUT (.i_clk(clk), .i_rst_n(rst_n),
    .i_ce(1'b1), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
    .i_convert_start_n(convert_start_n_n), .i_conv_done(conv_done),
    .i_conv_data(conv_data), .o_dout(dout), .o_eoc_n(eoc_n),
    .o_conv_start(conv_start), .o_conv_temp(conv_temp),
    .o_conv_chan(conv_chan));
  adcsq_host host (.i_clk(clk), .i_dout(dout), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_din(din), .o_convert_start_n(convert_start_n_n));
  // Converter stub: rising data values so averages are visible
  always @(negedge clk) begin
    dly <= {dly[1:0], conv_start};
    conv_done <= dly[2];
    if (dly[2]) begin
      conv_data <= 12'h100 + n_conv[11:0];
      n_conv <= n_conv + 1;
    end
    if (conv_start && n_conv == 0) first_temp <= conv_temp;
    if (conv_start) last_chan <= conv_chan;
  end
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Bounded wait for the end flag; a hang counts as a mismatch
  task automatic wait_eoc;
    int t;
    t = 0;
    while (eoc_n !== 1'b0 && t < 20000) begin
      @(negedge clk);
      t++;
    end
    `CHECK(t < 20000, 1'b1)
  endtask
  // Watchdog well above the longest expected run
  initial begin
    #200000;
    mismatches++;
    $display("wrong value at %0t: run timed out", $time);
    complete_run();
  end
  // Main sequence: reset, table rows, then hand-written cases
  initial begin
    #1 rst_n = 1'b0;
    repeat (3) @(posedge clk);
    `CHECK({eoc_n, conv_start}, 2'b10)
    @(negedge clk) rst_n = 1'b1;
    repeat (2) @(negedge clk);
    foreach (rows[i]) begin
      host.frame(8'h18, word);
      host.frame(rows[i].avg, word);
      n_conv = 0;
      host.frame(rows[i].conv, word);
      wait_eoc();
      `CHECK(n_conv, rows[i].n * rows[i].res)
      host.frame(8'h00, word);
      `CHECK(word, {4'h0, 12'h100 + 12'((rows[i].n - 1) / 2)})
      `CHECK(last_chan, 4'h3)
      $display("test row %0d end", i);
    end
    host.frame(8'h18, word);
    host.frame(8'h00, word);
    `CHECK(word, 16'h0000)
    host.frame(8'h3c, word);
    host.frame(8'h17, word);
    n_conv = 0;
    host.frame(8'h9f, word);
    wait_eoc();
    `CHECK(n_conv, 2)
    `CHECK(first_temp, 1'b1)
    host.frame(8'h00, word);
    `CHECK(word, 16'h0100)
    host.frame(8'h00, word);
    `CHECK(word, 16'h0101)
    $display("test reset and temperature end");
    host.frame(8'h44, word);
    host.frame(8'hb6, word);
    n_conv = 0;
    repeat (600) @(negedge clk);
    `CHECK(n_conv, 0)
    host.start_pulse(12);
    wait_eoc();
    `CHECK({n_conv[1:0], last_chan}, 6'h16)
    host.start_pulse(12);
    `CHECK(eoc_n, 1'b1)
    wait_eoc();
    `CHECK(n_conv, 2)
    $display("test start pin mode end");
    host.frame(8'h54, word);
    host.frame(8'h30, word);
    host.frame(8'h18, word);
    host.frame(8'h96, word);
    n_conv = 0;
    // held 1.4 us; external reference needs no wake
    repeat (4) begin
      host.start_pulse(350);
      wait_eoc();
    end
    `CHECK(n_conv, 4)
    `CHECK(last_chan, 4'h2)
    host.frame(8'h00, word);
    `CHECK(word, 16'h0101)
    $display("test pulse per conversion mode end");
    complete_run();
  end
endmodule
bind adcsq_top adcsq_checker #(.REF_WAKE_CYC(REF_WAKE_CYC)) u_chk (.i_clk,
  .i_rst_n, .i_cs_n, .i_convert_start_n, .i_conv_done, .o_eoc_n,
  .o_conv_start, .o_conv_temp, .o_conv_chan);
